// >>> inc/oamx_pkg.sv
// Package for the OR/move instruction execute block.
// Assumes 14-bit instruction words and an 8-bit datapath with a 128-entry file.
package oamx_pkg;

  // Instruction word and field geometry.
  localparam int INSN_W     = 14;
  localparam int DATA_W     = 8;
  localparam int FADDR_W    = 7;
  localparam int DIR_BIT    = 7;
  localparam int OPC6_LSB   = 8;
  localparam int OPC4_LSB   = 10;

  // Opcode patterns, upper six bits of the word.
  localparam logic [5:0] OPC_OR_LIT   = 6'h38;
  localparam logic [5:0] OPC_OR_FILE  = 6'h04;
  localparam logic [5:0] OPC_MOV_FILE = 6'h08;
  // Load literal matches on the upper four bits only.
  localparam logic [3:0] OPC_LOAD_LIT = 4'hc;

  // Values after reset.
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic       ZERO_RST = 1'b0;

  // Every instruction here retires in one cycle.
  localparam int INSN_CYCLES = 1;

  typedef enum logic [2:0] {
    OAMX_OP_NONE,
    OAMX_OP_OR_LIT,
    OAMX_OP_LOAD_LIT,
    OAMX_OP_OR_FILE,
    OAMX_OP_MOV_FILE
  } oamx_op_t;

endpackage : oamx_pkg

// >>> hdl/oamx_exec.sv
// Decode and execute for OR-literal, load-literal, OR-file and move-file.
// Assumes the file register read port is combinational: file_rdata_i shows
// the register addressed by file_addr_o in the same cycle.
`timescale 1ns/1ps

// Function
// RL1 - OR literal into accumulator, write accumulator, zero flag from result.
// RL2 - OR accumulator with addressed file register, zero flag from result.
// RL3 - Direction bit 0 writes accumulator, 1 writes addressed file register.
// RL4 - Move file register to selected destination, zero flag from value moved.
// RL5 - Move with direction 1 leaves register unchanged but updates zero flag.
// RL6 - Load literal into accumulator, flags untouched, two don't-care bits ignored.
module oamx_exec (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        insn_valid_i,
  input  wire logic [13:0] insn_i,
  input  wire logic [7:0]  file_rdata_i,
  output logic [6:0]       file_addr_o,
  output logic [7:0]       file_wdata_o,
  output logic             file_we_o,
  output logic [7:0]       acc_o,
  output logic             zero_o,
  output logic             insn_known_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  oamx_pkg::oamx_op_t op;
  logic [7:0]         lit;
  logic               dir;
  logic [7:0]         result;
  logic               to_file;
  logic               touches_zero;
  logic [7:0]         acc_q;
  logic               zero_q;
  logic [7:0]         acc_d;
  logic               zero_d;

  // Decoding lives in one function so the priority between patterns sits in one place.
  function automatic oamx_pkg::oamx_op_t decode_op(input logic [13:0] w);
    logic [5:0] top6;
    top6 = w[13:oamx_pkg::OPC6_LSB];
    if (top6 == oamx_pkg::OPC_OR_LIT) begin
      return oamx_pkg::OAMX_OP_OR_LIT;
    end else if (w[13:oamx_pkg::OPC4_LSB] == oamx_pkg::OPC_LOAD_LIT) begin
      return oamx_pkg::OAMX_OP_LOAD_LIT; // see RL6
    end else if (top6 == oamx_pkg::OPC_OR_FILE) begin
      return oamx_pkg::OAMX_OP_OR_FILE;
    end else if (top6 == oamx_pkg::OPC_MOV_FILE) begin
      return oamx_pkg::OAMX_OP_MOV_FILE;
    end
    return oamx_pkg::OAMX_OP_NONE;
  endfunction : decode_op

  // Field extraction; an invalid cycle decodes as no operation.
  assign op           = insn_valid_i ? decode_op(insn_i) : oamx_pkg::OAMX_OP_NONE;
  assign lit          = insn_i[7:0];
  assign dir          = insn_i[oamx_pkg::DIR_BIT];
  assign file_addr_o  = insn_i[6:0];
  assign insn_known_o = (op != oamx_pkg::OAMX_OP_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Execute: compute result, destination and flag effect.

  // The move result is the file value itself, so a move back to the file
  // is not written at all and only the zero flag changes.
  // Limitation: the file read must settle within the cycle; a registered
  // memory would need a stall that this block does not provide.
  always_comb begin
    result       = acc_q;
    to_file      = 1'b0;
    touches_zero = 1'b0;
    case (op)
      oamx_pkg::OAMX_OP_OR_LIT: begin
        result       = acc_q | lit; // see RL1
        touches_zero = 1'b1;
      end
      oamx_pkg::OAMX_OP_LOAD_LIT: begin
        result = lit; // see RL6
      end
      oamx_pkg::OAMX_OP_OR_FILE: begin
        result       = acc_q | file_rdata_i; // see RL2
        to_file      = dir; // see RL3
        touches_zero = 1'b1;
      end
      oamx_pkg::OAMX_OP_MOV_FILE: begin
        result       = file_rdata_i; // see RL4
        to_file      = dir; // see RL5
        touches_zero = 1'b1;
      end
      default: begin
        result = acc_q;
      end
    endcase
  end

  // Suppressing the write on a move-to-self saves a needless file cycle.
  assign file_we_o    = to_file && (op == oamx_pkg::OAMX_OP_OR_FILE); // see RL3
  assign file_wdata_o = result;

  // Next state of accumulator and zero flag.
  assign acc_d  = (insn_known_o && !to_file) ? result : acc_q; // see RL3
  assign zero_d = touches_zero ? (result == 8'h00) : zero_q; // see RL4

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator.

  // Updated once per instruction cycle.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_q <= oamx_pkg::ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Zero flag; load literal leaves it alone.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      zero_q <= oamx_pkg::ZERO_RST;
    end else begin
      zero_q <= zero_d;
    end
  end

  assign acc_o  = acc_q;
  assign zero_o = zero_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // All checks share one clock; reset disables them so that a mid-run reset
  // cannot trip a check that still waits for its next cycle.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  chk_or_lit_acc: assert property ( // see RL1
    op == oamx_pkg::OAMX_OP_OR_LIT |=> acc_q == ($past(acc_q) | $past(lit))
      && zero_q == (($past(acc_q) | $past(lit)) == 8'h00))
    else $error("OR literal result wrong");

  chk_or_file_z: assert property ( // see RL2
    op == oamx_pkg::OAMX_OP_OR_FILE |=>
      zero_q == (($past(acc_q) | $past(file_rdata_i)) == 8'h00))
    else $error("OR file zero flag wrong");

  chk_dir_file: assert property ( // see RL3
    op == oamx_pkg::OAMX_OP_OR_FILE && dir |->
      file_we_o && file_wdata_o == (acc_q | file_rdata_i) ##1 acc_q == $past(acc_q))
    else $error("OR file to file wrong");

  chk_dir_acc: assert property ( // see RL3
    op == oamx_pkg::OAMX_OP_OR_FILE && !dir |-> !file_we_o ##1
      acc_q == ($past(acc_q) | $past(file_rdata_i)))
    else $error("OR file to acc wrong");

  chk_mov_acc: assert property ( // see RL4
    op == oamx_pkg::OAMX_OP_MOV_FILE && !dir |=>
      acc_q == $past(file_rdata_i) && zero_q == ($past(file_rdata_i) == 8'h00))
    else $error("Move to acc wrong");

  chk_mov_self: assert property ( // see RL5
    op == oamx_pkg::OAMX_OP_MOV_FILE && dir |-> !file_we_o ##1
      $stable(acc_q) && zero_q == ($past(file_rdata_i) == 8'h00))
    else $error("Move to self wrong");

  chk_load_lit: assert property ( // see RL6
    op == oamx_pkg::OAMX_OP_LOAD_LIT |=> acc_q == $past(lit) && $stable(zero_q))
    else $error("Load literal wrong");

  chk_idle_hold: assert property (
    !insn_known_o |=> $stable(acc_q) && $stable(zero_q))
    else $error("State moved without instruction");

  // A file write belongs to OR-file with direction 1 alone; any other source
  // would overwrite a register that software still expects intact.
  chk_write_only_or: assert property ( // see RL3
    file_we_o |-> op == oamx_pkg::OAMX_OP_OR_FILE && dir)
    else $error("File write without OR file to file");

  // Literal forms never touch the file.
  chk_lit_no_write: assert property ( // see RL1
    op == oamx_pkg::OAMX_OP_OR_LIT || op == oamx_pkg::OAMX_OP_LOAD_LIT |-> !file_we_o)
    else $error("Literal instruction wrote the file");

  // Whenever a flag-setting result lands in the accumulator, the two agree.
  chk_zero_tracks_acc: assert property ( // see RL1
    op == oamx_pkg::OAMX_OP_OR_LIT
      || (op == oamx_pkg::OAMX_OP_OR_FILE && !dir)
      || (op == oamx_pkg::OAMX_OP_MOV_FILE && !dir) |=>
      zero_q == (acc_q == 8'h00))
    else $error("Zero flag disagrees with accumulator");

  // The two don't-care bits of load literal must not change the decode.
  chk_load_dc_bits: assert property ( // see RL6
    insn_valid_i && insn_i[13:10] == oamx_pkg::OPC_LOAD_LIT |->
      op == oamx_pkg::OAMX_OP_LOAD_LIT && acc_d == insn_i[7:0])
    else $error("Load literal decode depends on don't-care bits");

  // The OR-literal pattern must never fall through to another decode.
  chk_or_lit_decode: assert property ( // see RL1
    insn_valid_i && insn_i[13:8] == oamx_pkg::OPC_OR_LIT |->
      op == oamx_pkg::OAMX_OP_OR_LIT && insn_known_o)
    else $error("OR literal not decoded");

  // An invalid cycle neither claims an instruction nor writes.
  chk_invalid_quiet: assert property ( // see RL3
    !insn_valid_i |-> !insn_known_o && !file_we_o)
    else $error("Invalid cycle acted");

  // The file address is the operand field of the word in the same cycle.
  chk_file_addr: assert property ( // see RL2
    op == oamx_pkg::OAMX_OP_OR_FILE || op == oamx_pkg::OAMX_OP_MOV_FILE |->
      file_addr_o == insn_i[6:0])
    else $error("File address not the operand field");

  // Covers mark the scenarios that the bench must reach.
  cov_or_lit_zero: cover property (op == oamx_pkg::OAMX_OP_OR_LIT ##1 zero_q);
  cov_or_file_wr: cover property (file_we_o);
  cov_mov_test: cover property (op == oamx_pkg::OAMX_OP_MOV_FILE && dir);
  cov_or_file_acc: cover property (op == oamx_pkg::OAMX_OP_OR_FILE && !dir);
  cov_load_then_or: cover property (
    op == oamx_pkg::OAMX_OP_LOAD_LIT ##1 op == oamx_pkg::OAMX_OP_OR_LIT);

endmodule : oamx_exec

// >>> verification/oamx_file_model.sv
// File register model on the far side of the execute block.
// Assumes a combinational read port and a write on the rising edge.
`timescale 1ns/1ps
module oamx_file_model (
  input  wire logic       mclk_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       we_i,
  output logic [7:0]      rdata_o
);
  logic [7:0] regs_q [128];
  // A known pattern the bench mirrors; entry 30 holds zero.
  initial begin
    for (int i = 0; i < 128; i++) begin
      regs_q[i] = 8'(i * 3) ^ 8'h5a;
    end
  end
  // Reads are combinational, as the execute block expects.
  assign rdata_o = regs_q[addr_i];
  // Writes land on the edge that takes the instruction.
  always @(posedge mclk_i) begin
    if (we_i) begin
      regs_q[addr_i] <= wdata_i;
    end
  end
endmodule : oamx_file_model

// >>> verification/or_and_move_insn_exec_tb.sv
// Self-checking bench for the OR and move execute block.
// Assumes one instruction per cycle and a combinational file read.
`timescale 1ns/1ps
module or_and_move_insn_exec_tb;
  logic        mclk_i, resetn_i, insn_valid_i, file_we_o, zero_o, insn_known_o, zero_e;
  logic [13:0] insn_i, w;
  logic [7:0]  file_rdata_i, file_wdata_o, acc_o, acc_e, mem_e [128];
  logic [6:0]  file_addr_o;
  logic [31:0] s;
  int          failures, samples_checked, seed;
  oamx_exec dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .insn_valid_i(insn_valid_i),
    .insn_i(insn_i), .file_rdata_i(file_rdata_i), .file_addr_o(file_addr_o),
    .file_wdata_o(file_wdata_o), .file_we_o(file_we_o), .acc_o(acc_o), .zero_o(zero_o),
    .insn_known_o(insn_known_o));
  oamx_file_model mem_u (.mclk_i(mclk_i), .addr_i(file_addr_o), .wdata_i(file_wdata_o),
    .we_i(file_we_o), .rdata_o(file_rdata_i));
  // Free-running 125 MHz clock.
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // Reset for ten cycles; the file contents survive it, as real storage would.
  task automatic do_reset();
    resetn_i = 1'b0;
    insn_valid_i = 1'b0;
    repeat (10) @(negedge mclk_i);
    check(acc_o, oamx_pkg::ACC_RST);
    check({7'h00, zero_o}, {7'h00, oamx_pkg::ZERO_RST});
    acc_e = oamx_pkg::ACC_RST;
    zero_e = oamx_pkg::ZERO_RST;
    resetn_i = 1'b1;
  endtask : do_reset
  // Called at a falling edge; drives one word and checks it at the next falling edge.
  task automatic step(input logic v, input logic [13:0] i);
    logic [7:0] r, res;
    logic       hit, wr;
    insn_valid_i = v;
    insn_i = i;
    r = mem_e[i[6:0]];
    hit = v && (i[13:8] == 6'h38 || i[13:10] == 4'hc || i[13:8] == 6'h04 || i[13:8] == 6'h08);
    res = i[13] ? (i[11] ? acc_e | i[7:0] : i[7:0]) : (i[10] ? acc_e | r : r);
    wr = hit && i[13:8] == 6'h04 && i[7];
    #1;
    check({7'h00, insn_known_o}, {7'h00, hit});
    check({7'h00, file_we_o}, {7'h00, wr});
    if (hit && !i[13]) check({1'b0, file_addr_o}, {1'b0, i[6:0]});
    if (wr) check(file_wdata_o, res);
    if (wr) mem_e[i[6:0]] = res;
    else if (hit && (i[13] || !i[7])) acc_e = res;
    if (hit && i[13:10] != 4'hc) zero_e = (res == 8'h00);
    @(negedge mclk_i);
    check(acc_o, acc_e);
    check({7'h00, zero_o}, {7'h00, zero_e});
    check(mem_u.regs_q[i[6:0]], mem_e[i[6:0]]);
  endtask : step
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #60000;
    failures++;
    stop_test();
  end
  // Corner cases first, then random traffic, a reset in mid-run, more traffic.
  initial begin
    seed = 32'h3e77;
    resetn_i = 1'b0;
    insn_valid_i = 1'b0;
    insn_i = 14'h0000;
    for (int k = 0; k < 128; k++) mem_e[k] = 8'(k * 3) ^ 8'h5a;
    @(negedge mclk_i);
    do_reset();
    step(1'b1, 14'h309a);
    step(1'b1, 14'h3c9a);
    step(1'b1, 14'h3835);
    step(1'b1, 14'h3300);
    step(1'b1, 14'h3800);
    step(1'b1, 14'h109e);
    step(1'b1, 14'h089e);
    step(1'b1, 14'h081e);
    step(1'b0, 14'h3835);
    step(1'b1, 14'h3fff);
    $display("Corner cases done");
    for (int n = 0; n < 600; n++) begin
      if (n == 300) do_reset();
      w = 14'($random(seed));
      s = $random(seed);
      case (s[2:0])
        3'h0: w[13:8] = 6'h38;
        3'h1: w[13:10] = 4'hc;
        3'h2: w[13:8] = 6'h04;
        3'h3: w[13:8] = 6'h08;
        default: ;
      endcase
      step(s[3] | s[4], w);
    end
    $display("Random traffic done");
    stop_test();
  end
endmodule : or_and_move_insn_exec_tb
